// ===== inc/term_logic_cfg.svh
// Offsets, field positions, reset values and timing counts for the terminal logic.
// Assumes a 20 MHz control clock and a 32-bit classic Wishbone register port.
`ifndef TERM_LOGIC_CFG_SVH
`define TERM_LOGIC_CFG_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL 6'h00
`define OFS_MAIN 6'h04
`define OFS_LOW 6'h08
`define OFS_MID 6'h0C
`define OFS_HIGH 6'h10
`define OFS_FMAX 6'h14
`define OFS_FMIN 6'h18
`define OFS_IN_LO 6'h1C
`define OFS_IN_HI 6'h20
`define OFS_OUT 6'h24
`define OFS_CNT_TGT 6'h28
`define OFS_CNT_MID 6'h2C
`define OFS_UNI1 6'h30
`define OFS_UNI2 6'h34
`define OFS_STATUS 6'h38
`define OFS_SETPT 6'h3C
// ****************************************
// Control fields and reset values
// ****************************************
`define CTRL_MODE_LSB 0
`define CTRL_SRC_LSB 4
`define CTRL_MEM_BIT 8
`define RST_OUT_FUNC 32'h0002_0501
`define RST_FMAX 16'h9C40
`define RST_MAIN 16'h1388
// ****************************************
// Timing
// ****************************************
`define CLK_HZ 20000000
`define TICK_US 1000
`define DEB_MS 2
`define REP_FAST_MS 50
`define REP_SLOW_MS 100
`define FAST_STEPS 8'h14
`define FAST_UNIT 16'h000A
`define SLOW_UNIT 16'h0001
`define CNT_MAX 16'hFFFF
`endif

// ===== inc/term_logic_pkg.sv
// Types shared by the terminal logic.
// Assumes term_logic_cfg.svh supplies the numbers.
package term_logic_pkg;
	typedef logic [5:0] func_code_t;
	typedef logic [15:0] freq_t;
	typedef enum logic [2:0] {
		ADJ_IDLE = 3'b001,
		ADJ_FAST = 3'b010,
		ADJ_SLOW = 3'b100
	} adj_state_t;
endpackage : term_logic_pkg

// ===== src/term_logic.sv
// Multi-function input decoding and multi-function output contacts of a drive controller.
// Assumes drive status inputs are on clk_i; terminal pins are asynchronous contacts.
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "term_logic_cfg.svh"

// Notes on behaviour
// - Ramp selection from terminals only in speed modes 0, 1 and 2.
// - Codes 23 and 24 form a two-bit ramp selector, ramp 1 to 4.
// - Running with no speed input: main setpoint; else chosen preset.
// - High, middle, low speed inputs honoured only in speed mode 1.
// - Speed inputs resolve high first, then middle, then low.
// - Up alone raises, down alone lowers, both together hold.
// - Up and down act only when frequency source is panel, value 0.
// - Up stops at maximum frequency, down stops at minimum or lower limit.
// - Held up or down steps fast at first, then at constant rate.
// - Power loss keeps the main setting unless adjust memory is enabled.
// - Binary multi-speed inputs act only in speed mode 2.
// - Count reaching target activates the counter-reach contact.
// - After reaching target, counting waits for a counter reset.
// - Counter saturates at 65535 and ignores further pulses.
// - Four contacts, codes 00 to 32, defaults 01, 05, 02, 00.
// - Codes 00 to 05: never, run, fault, zero speed, braking, reached.
// - Codes 06, 07 uniform thresholds; 08 accelerating; 09 decelerating.
// - Codes 10 to 13: drive overload, motor overload, over-torque, low voltage.
// - Code 14 pulses at step end, code 15 at program cycle end.
// - Code 16 count equals target; 17 count at least intermediate.
// - Codes 18, 19 timers; 20 current loop open; 28, 29 feedback limits.
module term_logic #(
	parameter int unsigned TICK_CYC = `CLK_HZ / 1000000 * `TICK_US
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [5:0] term_i,
	input wire logic running_i,
	input wire logic fault_i,
	input wire logic [15:0] out_freq_i,
	input wire logic [15:0] start_freq_i,
	input wire logic dc_brake_i,
	input wire logic accel_i,
	input wire logic decel_i,
	input wire logic drive_ovl_i,
	input wire logic motor_ovl_i,
	input wire logic torque_i,
	input wire logic low_volt_i,
	input wire logic step_end_i,
	input wire logic cycle_end_i,
	input wire logic timer1_i,
	input wire logic timer2_i,
	input wire logic current_loop_open_i,
	input wire logic fb_low_i,
	input wire logic fb_high_i,
	output logic [3:0] contact_o,
	output logic [1:0] ramp_sel_o,
	output logic [2:0] multi_speed_o,
	output logic [15:0] freq_target_o
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic code_on(input term_logic_pkg::func_code_t code, input logic [32:0] cond);
		logic r;
		r = 1'b0;
		if (code <= 6'h20) begin
			r = cond[code[5:0]];
		end
		return r;
	endfunction : code_on

	// ****************************************
	// Registers
	// ****************************************
	logic [31:0] ctrl_q;
	term_logic_pkg::freq_t main_q, low_q, mid_q, high_q, fmax_q, fmin_q;
	logic [31:0] in_lo_q, in_hi_q, out_q;
	logic [15:0] cnt_tgt_q, cnt_mid_q;
	term_logic_pkg::freq_t uni1_q, uni2_q;
	logic wr;
	logic [1:0] mode;
	logic [3:0] src;
	logic adj_step;
	term_logic_pkg::freq_t adj_q, adj_d;

	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign mode = ctrl_q[`CTRL_MODE_LSB +: 2];
	assign src = ctrl_q[`CTRL_SRC_LSB +: 4];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	// Function codes, defaults 01 05 02 00
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= 32'h0000_0000;
			low_q <= 16'h0000;
			mid_q <= 16'h0000;
			high_q <= 16'h0000;
			fmax_q <= `RST_FMAX;
			fmin_q <= 16'h0000;
			in_lo_q <= 32'h0000_0000;
			in_hi_q <= 32'h0000_0000;
			out_q <= `RST_OUT_FUNC;
			cnt_tgt_q <= 16'h0000;
			cnt_mid_q <= 16'h0000;
			uni1_q <= 16'h0000;
			uni2_q <= 16'h0000;
		end else if (wr) begin
			unique case (wb_adr_i)
				`OFS_CTRL: ctrl_q <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_01F3;
				`OFS_LOW: low_q <= 16'(merge({16'h0000, low_q}, wb_dat_i, wb_sel_i));
				`OFS_MID: mid_q <= 16'(merge({16'h0000, mid_q}, wb_dat_i, wb_sel_i));
				`OFS_HIGH: high_q <= 16'(merge({16'h0000, high_q}, wb_dat_i, wb_sel_i));
				`OFS_FMAX: fmax_q <= 16'(merge({16'h0000, fmax_q}, wb_dat_i, wb_sel_i));
				`OFS_FMIN: fmin_q <= 16'(merge({16'h0000, fmin_q}, wb_dat_i, wb_sel_i));
				`OFS_IN_LO: in_lo_q <= merge(in_lo_q, wb_dat_i, wb_sel_i);
				`OFS_IN_HI: in_hi_q <= merge(in_hi_q, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
				`OFS_OUT: out_q <= merge(out_q, wb_dat_i, wb_sel_i);
				`OFS_CNT_TGT: cnt_tgt_q <= 16'(merge({16'h0000, cnt_tgt_q}, wb_dat_i, wb_sel_i));
				`OFS_CNT_MID: cnt_mid_q <= 16'(merge({16'h0000, cnt_mid_q}, wb_dat_i, wb_sel_i));
				`OFS_UNI1: uni1_q <= 16'(merge({16'h0000, uni1_q}, wb_dat_i, wb_sel_i));
				`OFS_UNI2: uni2_q <= 16'(merge({16'h0000, uni2_q}, wb_dat_i, wb_sel_i));
				default: ;
			endcase
		end
	end

	// Adjusted value written back only when memory is enabled
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			main_q <= `RST_MAIN;
		end else if (wr && wb_adr_i == `OFS_MAIN) begin
			main_q <= 16'(merge({16'h0000, main_q}, wb_dat_i, wb_sel_i));
		end else if (adj_step && ctrl_q[`CTRL_MEM_BIT]) begin
			main_q <= adj_d;
		end
	end

	// ****************************************
	// Terminal sampling
	// ****************************************
	logic [31:0] tick_cnt_q;
	logic tick_q;
	logic [5:0] sync1_q, sync2_q, deb_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_q <= 32'h0000_0000;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == 32'(TICK_CYC - 1));
			tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC - 1)) ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
		end else begin
			sync1_q <= term_i;
			sync2_q <= sync1_q;
		end
	end

	// Stability must span the minimum pulse width, so counts cannot double on bounce
	generate
		for (genvar i = 0; i < 6; i++) begin : g_deb
			logic [1:0] hold_q;
			logic level_q;
			assign deb_q[i] = level_q;
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					hold_q <= 2'h0;
					level_q <= 1'b0;
				end else if (sync2_q[i] == level_q) begin
					hold_q <= 2'h0;
				end else if (tick_q) begin
					if (hold_q == 2'(`DEB_MS - 1)) begin
						level_q <= sync2_q[i];
						hold_q <= 2'h0;
					end else begin
						hold_q <= hold_q + 2'h1;
					end
				end
			end
		end
	endgenerate

	// Function active vector: bit k, 1 to 32, is set when any terminal holding code k is closed; bit 0 stays clear
	logic [32:0] fn;
	logic [47:0] in_codes;
	assign in_codes = {in_hi_q[15:0], in_lo_q};
	always_comb begin
		fn = 33'h0_0000_0000;
		for (int i = 0; i < 6; i++) begin
			if (code_on(in_codes[8*i +: 6], 33'h1_FFFF_FFFE)) begin
				fn[in_codes[8*i +: 6]] = fn[in_codes[8*i +: 6]] | deb_q[i];
			end
		end
	end

	// ****************************************
	// Ramp and speed selection
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ramp_sel_o <= 2'h0;
			multi_speed_o <= 3'h0;
		end else begin
			if (mode != 2'h3) begin
				ramp_sel_o <= {fn[24], fn[23]};
			end else begin
				ramp_sel_o <= 2'h0;
			end
			// Binary speeds in mode 2 only
			multi_speed_o <= (mode == 2'h2) ? {fn[22], fn[21], fn[20]} : 3'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			freq_target_o <= 16'h0000;
		end else if (!running_i) begin
			freq_target_o <= 16'h0000;
		// Speed terminals in mode 1 only
		end else if (mode == 2'h1) begin
			if (fn[17]) begin
				freq_target_o <= high_q;
			end else if (fn[18]) begin
				freq_target_o <= mid_q;
			end else if (fn[19]) begin
				freq_target_o <= low_q;
			end else begin
				freq_target_o <= adj_q;
			end
		end else begin
			freq_target_o <= adj_q;
		end
	end

	// ****************************************
	// Up and down adjustment
	// ****************************************
	term_logic_pkg::adj_state_t st_q;
	logic [7:0] ms_q, steps_q;
	logic up, dn;
	term_logic_pkg::freq_t unit;

	assign up = fn[25] && !fn[26] && src == 4'h0;
	assign dn = fn[26] && !fn[25] && src == 4'h0;
	assign unit = (st_q == term_logic_pkg::ADJ_SLOW) ? `SLOW_UNIT : `FAST_UNIT;

	// Fast steps first, then constant rate
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= term_logic_pkg::ADJ_IDLE;
			ms_q <= 8'h00;
			steps_q <= 8'h00;
		end else if (!(up || dn)) begin
			st_q <= term_logic_pkg::ADJ_IDLE;
			ms_q <= 8'h00;
			steps_q <= 8'h00;
		end else begin
			unique case (st_q)
				term_logic_pkg::ADJ_IDLE: st_q <= term_logic_pkg::ADJ_FAST;
				term_logic_pkg::ADJ_FAST: begin
					if (adj_step) begin
						steps_q <= steps_q + 8'h01;
						if (steps_q == `FAST_STEPS) begin
							st_q <= term_logic_pkg::ADJ_SLOW;
						end
					end
				end
				term_logic_pkg::ADJ_SLOW: ;
			endcase
			if (adj_step) begin
				ms_q <= 8'h00;
			end else if (tick_q) begin
				ms_q <= ms_q + 8'h01;
			end
		end
	end

	assign adj_step = (st_q == term_logic_pkg::ADJ_IDLE && (up || dn))
		|| (st_q == term_logic_pkg::ADJ_FAST && tick_q && ms_q == 8'(`REP_FAST_MS - 1))
		|| (st_q == term_logic_pkg::ADJ_SLOW && tick_q && ms_q == 8'(`REP_SLOW_MS - 1));

	always_comb begin
		adj_d = adj_q;
		if (up) begin
			adj_d = (fmax_q - adj_q < unit) ? fmax_q : adj_q + unit;
		end else if (dn) begin
			adj_d = (adj_q < fmin_q + unit) ? fmin_q : adj_q - unit;
		end
	end

	// Setpoint reloads from the main setting after reset, so unsaved adjustment is lost
	logic load_q;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			adj_q <= 16'h0000;
			load_q <= 1'b1;
		end else if (load_q || (wr && wb_adr_i == `OFS_MAIN)) begin
			adj_q <= load_q ? main_q : 16'(merge({16'h0000, main_q}, wb_dat_i, wb_sel_i));
			load_q <= 1'b0;
		end else if (adj_step) begin
			adj_q <= adj_d;
		end
	end

	// ****************************************
	// Event counter
	// ****************************************
	logic [15:0] count_q;
	logic pulse_q, reached_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= fn[27];
		end
	end

	// Debounce window assumes the source honours 2 ms levels
	always_ff @(posedge clk_i) begin
		if (rst_i || fn[28]) begin
			count_q <= 16'h0000;
			reached_q <= 1'b0;
		end else begin
			if (fn[27] && !pulse_q && !reached_q && count_q != `CNT_MAX) begin
				count_q <= count_q + 16'h0001;
			end
			if (count_q == cnt_tgt_q && cnt_tgt_q != 16'h0000) begin
				reached_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// Output contacts
	// ****************************************
	logic [32:0] cond;
	always_comb begin
		cond = 33'h0_0000_0000;
		cond[1] = running_i || out_freq_i != 16'h0000;
		cond[2] = fault_i;
		cond[3] = out_freq_i < start_freq_i;
		cond[4] = dc_brake_i;
		cond[5] = running_i && out_freq_i == freq_target_o;
		cond[6] = out_freq_i >= uni1_q;
		cond[7] = out_freq_i >= uni2_q;
		cond[8] = accel_i;
		cond[9] = decel_i;
		cond[10] = drive_ovl_i;
		cond[11] = motor_ovl_i;
		cond[12] = torque_i;
		cond[13] = low_volt_i;
		cond[14] = step_end_i;
		cond[15] = cycle_end_i;
		cond[16] = count_q == cnt_tgt_q || reached_q;
		cond[17] = count_q >= cnt_mid_q;
		cond[18] = timer1_i;
		cond[19] = timer2_i;
		cond[20] = current_loop_open_i;
		cond[28] = fb_low_i;
		cond[29] = fb_high_i;
	end

	// One process owns all four contacts, so no bit has a second driver
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			contact_o <= 4'h0;
		end else begin
			for (int k = 0; k < 4; k++) begin
				contact_o[k] <= code_on(out_q[8*k +: 6], cond);
			end
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
			unique case (wb_adr_i)
				`OFS_CTRL: wb_dat_o <= ctrl_q;
				`OFS_MAIN: wb_dat_o <= {16'h0000, main_q};
				`OFS_LOW: wb_dat_o <= {16'h0000, low_q};
				`OFS_MID: wb_dat_o <= {16'h0000, mid_q};
				`OFS_HIGH: wb_dat_o <= {16'h0000, high_q};
				`OFS_FMAX: wb_dat_o <= {16'h0000, fmax_q};
				`OFS_FMIN: wb_dat_o <= {16'h0000, fmin_q};
				`OFS_IN_LO: wb_dat_o <= in_lo_q;
				`OFS_IN_HI: wb_dat_o <= in_hi_q;
				`OFS_OUT: wb_dat_o <= out_q;
				`OFS_CNT_TGT: wb_dat_o <= {16'h0000, cnt_tgt_q};
				`OFS_CNT_MID: wb_dat_o <= {16'h0000, cnt_mid_q};
				`OFS_UNI1: wb_dat_o <= {16'h0000, uni1_q};
				`OFS_UNI2: wb_dat_o <= {16'h0000, uni2_q};
				`OFS_STATUS: wb_dat_o <= {count_q, 3'h0, reached_q, contact_o, 2'h0, deb_q};
				`OFS_SETPT: wb_dat_o <= {16'h0000, adj_q};
				default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
endmodule : term_logic
`default_nettype wire

// ===== sim/term_logic_monitor.sv
// Port checker for the terminal logic.
// Assumes a bind to term_logic; it shadows the CTRL mode and the OUT codes.
`timescale 1ns/100ps
`default_nettype none
`include "term_logic_cfg.svh"
module term_logic_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic running_i,
	input wire logic fault_i,
	input wire logic [15:0] out_freq_i,
	input wire logic [15:0] start_freq_i,
	input wire logic dc_brake_i,
	input wire logic accel_i,
	input wire logic decel_i,
	input wire logic drive_ovl_i,
	input wire logic motor_ovl_i,
	input wire logic torque_i,
	input wire logic low_volt_i,
	input wire logic step_end_i,
	input wire logic cycle_end_i,
	input wire logic timer1_i,
	input wire logic timer2_i,
	input wire logic current_loop_open_i,
	input wire logic fb_low_i,
	input wire logic fb_high_i,
	input wire logic [3:0] contact_o,
	input wire logic [2:0] multi_speed_o,
	input wire logic [15:0] freq_target_o
);
	// ****
	// Shadow state
	// ****
	logic take;
	logic [31:0] out_q;
	logic [1:0] mode_q;
	logic [3:0] hot;
	logic [3:0] known;
	assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_q <= `RST_OUT_FUNC;
			mode_q <= 2'h0;
		end else if (take && wb_we_i) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_adr_i == `OFS_OUT && wb_sel_i[b]) out_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
			end
			if (wb_adr_i == `OFS_CTRL && wb_sel_i[0]) mode_q <= wb_dat_i[1:0];
		end
	end
	// Codes 05 to 07, 16 and 17 hang on hidden state, so they are left out
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			known[i] = 1'b1;
			case (out_q[8*i +: 8])
				8'h01: hot[i] = running_i | (out_freq_i != 16'h0000);
				8'h02: hot[i] = fault_i;
				8'h03: hot[i] = out_freq_i < start_freq_i;
				8'h04: hot[i] = dc_brake_i;
				8'h08: hot[i] = accel_i;
				8'h09: hot[i] = decel_i;
				8'h0A: hot[i] = drive_ovl_i;
				8'h0B: hot[i] = motor_ovl_i;
				8'h0C: hot[i] = torque_i;
				8'h0D: hot[i] = low_volt_i;
				8'h0E: hot[i] = step_end_i;
				8'h0F: hot[i] = cycle_end_i;
				8'h12: hot[i] = timer1_i;
				8'h13: hot[i] = timer2_i;
				8'h14: hot[i] = current_loop_open_i;
				8'h1C: hot[i] = fb_low_i;
				8'h1D: hot[i] = fb_high_i;
				default: begin
					hot[i] = 1'b0;
					known[i] = !(out_q[8*i +: 8] inside {8'h05, 8'h06, 8'h07, 8'h10, 8'h11});
				end
			endcase
		end
	end
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence req_s;
		take;
	endsequence
	sequence answer_s;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_bus_answer: assert property (req_s |=> answer_s) else $error("ack late or long");
	a_ack_cause: assert property (wb_ack_o |-> $past(take)) else $error("ack without request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_read_stands: assert property (!take |=> $stable(wb_dat_o)) else $error("read data moved");
	a_reset_quiet: assert property ($fell(rst_i) |-> contact_o == 4'h0 ##1 contact_o == 4'h0 && freq_target_o == 16'h0000)
		else $error("outputs busy after reset");
	a_stop_target: assert property (!running_i |=> freq_target_o == 16'h0000) else $error("target while stopped");
	a_binary_gate: assert property ((mode_q != 2'h2) [*2] |-> multi_speed_o == 3'h0) else $error("binary speed leak");
	a_contact_status: assert property (1'b1 |=> ((contact_o ^ $past(hot)) & $past(known)) == 4'h0)
		else $error("contact mismatch");
endmodule : term_logic_monitor
bind term_logic term_logic_monitor mon (.*);
`default_nettype wire

// ===== sim/term_switches.sv
// Contact bank wired to the input terminals.
// Assumes the bench sets want_i just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module term_switches (
	input wire logic clk_i,
	input wire logic [5:0] want_i,
	output logic [5:0] term_o
);
	logic [5:0] old_q = 6'h00;
	logic [2:0] bounce_q = 3'h0;
	always @(posedge clk_i) begin
		if (want_i != old_q && bounce_q == 3'h0) begin
			bounce_q <= 3'h5;
		end else if (bounce_q != 3'h0) begin
			bounce_q <= bounce_q - 3'h1;
		end
		if (bounce_q == 3'h1) old_q <= want_i;
		term_o <= bounce_q[0] ? old_q : want_i;
	end
endmodule : term_switches
`default_nettype wire

// ===== sim/term_logic_tb.sv
// Self-checking bench for the terminal logic.
// Assumes the contact model bounces; the tick is cut to 4 cycles.
`timescale 1ns/100ps
`default_nettype none
`include "term_logic_cfg.svh"
module term_logic_tb;
	logic clk, rst, cyc, we, ack, run, stp, cye;
	logic [5:0] adr, want, term;
	logic [3:0] sel, con;
	logic [31:0] wdat, rdat, rd;
	logic [12:0] st;
	logic [15:0] ofq, sfq, tgt;
	logic [1:0] ramp;
	logic [2:0] ms;
	int num_errors = 0;
	int cmp_count = 0;
	logic [7:0] codes [13] = '{8'h02, 8'h04, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h12, 8'h13, 8'h14, 8'h1C, 8'h1D};
	logic [5:0] sin [6] = '{6'h1, 6'h3, 6'h2, 6'h5, 6'h7, 6'h0};
	logic [15:0] spd [6] = '{16'h0100, 16'h0200, 16'h0200, 16'h0300, 16'h0300, 16'h1388};
	term_logic #(.TICK_CYC(4)) uut (
		.clk_i(clk),
		.rst_i(rst),
		.wb_cyc_i(cyc),
		.wb_stb_i(cyc),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(sel),
		.wb_dat_i(wdat),
		.wb_dat_o(rdat),
		.wb_ack_o(ack),
		.term_i(term),
		.running_i(run),
		.fault_i(st[0]),
		.out_freq_i(ofq),
		.start_freq_i(sfq),
		.dc_brake_i(st[1]),
		.accel_i(st[2]),
		.decel_i(st[3]),
		.drive_ovl_i(st[4]),
		.motor_ovl_i(st[5]),
		.torque_i(st[6]),
		.low_volt_i(st[7]),
		.step_end_i(stp),
		.cycle_end_i(cye),
		.timer1_i(st[8]),
		.timer2_i(st[9]),
		.current_loop_open_i(st[10]),
		.fb_low_i(st[11]),
		.fb_high_i(st[12]),
		.contact_o(con),
		.ramp_sel_o(ramp),
		.multi_speed_o(ms),
		.freq_target_o(tgt)
	);
	term_switches sw (.clk_i(clk), .want_i(want), .term_o(term));
	// ****
	// Tasks
	// ****
	task automatic print_verdict();
		if (num_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	// Holds the request until ack is seen; only the watchdog ends a dead wait
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		rd = rdat;
		cyc <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask : wr
	task automatic rdc(input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(rd, e);
	endtask : rdc
	task automatic press(input logic [5:0] v);
		want <= v;
		tick(30);
	endtask : press
	// ****
	// Sequence
	// ****
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		tick(20000);
		num_errors++;
		print_verdict();
	end
	initial begin
		{rst, cyc, we, run, stp, cye} <= 6'h20;
		{adr, sel, wdat, want, st, ofq, sfq} <= '0;
		tick(4);
		rst <= 1'b0;
		rdc(`OFS_OUT, `RST_OUT_FUNC);
		rdc(`OFS_FMAX, {16'h0000, `RST_FMAX});
		wr(`OFS_SETPT, 32'hFFFF_FFFF);
		rdc(`OFS_SETPT, {16'h0000, `RST_MAIN});
		st <= 13'h0001;
		tick(3);
		chk(32'(con), 32'h4);
		foreach (codes[i]) begin
			bus(1'b1, `OFS_OUT, {codes[i], 24'h0}, 4'h8);
			st <= 13'h0001 << i;
			tick(3);
			chk(32'(con[3]), 32'h1);
			st <= 13'h0;
			tick(3);
			chk(32'(con[3]), 32'h0);
		end
		rdc(`OFS_OUT, 32'h1D02_0501);
		bus(1'b1, `OFS_OUT, 32'h0300_0000, 4'h8);
		sfq <= 16'h000A;
		tick(3);
		chk(32'(con[3]), 32'h1);
		ofq <= 16'h0014;
		tick(3);
		chk(32'(con[3]), 32'h0);
		wr(`OFS_UNI1, 32'h0020);
		bus(1'b1, `OFS_OUT, 32'h0600_0000, 4'h8);
		tick(3);
		chk(32'(con[3]), 32'h0);
		ofq <= 16'h0020;
		tick(3);
		chk(32'(con[3]), 32'h1);
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, `OFS_OUT, {8'h0E + 8'(k), 24'h0}, 4'h8);
			{cye, stp} <= 2'h1 << k;
			@(posedge clk);
			{cye, stp} <= 2'h0;
			@(posedge clk);
			chk(32'(con[3]), 32'h1);
			@(posedge clk);
			chk(32'(con[3]), 32'h0);
		end
		run <= 1'b1;
		ofq <= 16'h1388;
		tick(3);
		chk(32'(tgt), 32'h1388);
		chk(32'(con[1]), 32'h1);
		wr(`OFS_IN_LO, 32'h0000_1817);
		for (int v = 0; v < 4; v++) begin
			press(6'(v));
			chk(32'(ramp), 32'(v));
		end
		wr(`OFS_CTRL, 32'h3);
		tick(3);
		chk(32'(ramp), 32'h0);
		press(6'h0);
		wr(`OFS_CTRL, 32'h1);
		wr(`OFS_LOW, 32'h0100);
		wr(`OFS_MID, 32'h0200);
		wr(`OFS_HIGH, 32'h0300);
		wr(`OFS_IN_LO, 32'h0011_1213);
		foreach (sin[i]) begin
			press(sin[i]);
			chk(32'(tgt), 32'(spd[i]));
		end
		wr(`OFS_CTRL, 32'h0);
		press(6'h7);
		chk(32'(tgt), 32'h1388);
		press(6'h0);
		wr(`OFS_IN_LO, 32'h0016_1514);
		wr(`OFS_CTRL, 32'h2);
		press(6'h5);
		chk(32'(ms), 32'h5);
		wr(`OFS_CTRL, 32'h1);
		tick(3);
		chk(32'(ms), 32'h0);
		press(6'h0);
		wr(`OFS_CTRL, 32'h0);
		wr(`OFS_IN_LO, 32'h0000_1A19);
		wr(`OFS_MAIN, 32'h1000);
		wr(`OFS_FMAX, 32'h1020);
		wr(`OFS_FMIN, 32'h0FF0);
		press(6'h1);
		rdc(`OFS_SETPT, 32'h100A);
		tick(1000);
		rdc(`OFS_SETPT, 32'h1020);
		rdc(`OFS_MAIN, 32'h1000);
		press(6'h0);
		press(6'h2);
		rdc(`OFS_SETPT, 32'h1016);
		press(6'h3);
		tick(400);
		rdc(`OFS_SETPT, 32'h1016);
		press(6'h0);
		wr(`OFS_CTRL, 32'h10);
		press(6'h1);
		tick(300);
		rdc(`OFS_SETPT, 32'h1016);
		press(6'h0);
		wr(`OFS_CTRL, 32'h100);
		press(6'h2);
		rdc(`OFS_MAIN, 32'h100C);
		tick(1000);
		rdc(`OFS_SETPT, 32'h0FF0);
		press(6'h0);
		wr(`OFS_FMIN, 32'h0);
		wr(`OFS_MAIN, 32'h0);
		press(6'h1);
		tick(4300);
		rdc(`OFS_SETPT, 32'h00DC);
		tick(400);
		rdc(`OFS_SETPT, 32'h00DD);
		press(6'h0);
		wr(`OFS_IN_LO, 32'h0000_1C1B);
		wr(`OFS_CNT_TGT, 32'h3);
		wr(`OFS_CNT_MID, 32'h2);
		bus(1'b1, `OFS_OUT, 32'h1110_0000, 4'hC);
		repeat (2) begin
			press(6'h1);
			press(6'h0);
		end
		chk(32'(con[3:2]), 32'h2);
		press(6'h1);
		press(6'h0);
		chk(32'(con[3:2]), 32'h3);
		press(6'h1);
		press(6'h0);
		bus(1'b0, `OFS_STATUS, 32'h0, 4'hF);
		chk(rd & 32'hFFFF_1000, 32'h0003_1000);
		press(6'h2);
		press(6'h0);
		chk(32'(con[3:2]), 32'h0);
		print_verdict();
	end
endmodule : term_logic_tb
`default_nettype wire
